//--- fcfg_host.sv
// Host controller model that drives the flash serial pins
`timescale 1ns/1ns
`default_nettype none
module fcfg_host (
   input wire logic clk_sys,
   input wire logic dq1_out,
   output var fcfg_pkg::fcfg_pins_s pins
);
   // Idle pins: deselected, clock low, hold/reset line pulled up
   initial begin
      pins = '{cs_n: 1'b1, sclk: 1'b0, dq0: 1'b0, dq3: 1'b1};
   end
   // One frame: opcode, nw bits out, nd dummy clocks, then bits in
   task automatic xfer(input logic [7:0] op, input logic [23:0] wd, input int nw,
      input int nd, input int nr, output logic [159:0] rd);
      logic [31:0] sh;
      sh = {op, wd << (24 - nw)};
      rd = '0;
      @(posedge clk_sys);
      #2 pins.cs_n = 1'b0;
      for (int i = 0; i < 8 + nw + nd + nr; i++) begin // Dummies per count
         pins.dq0 = sh[31];
         sh = sh << 1;
         #200 pins.sclk = 1'b1;
         rd = {rd[158:0], dq1_out};
         #200 pins.sclk = 1'b0;
      end
      #200 pins.cs_n = 1'b1;
      pins.dq0 = ~pins.dq0; // Released line must not show stale data
      #1000;
   endtask : xfer
   // Register write, always preceded by its own write-enable frame
   task automatic wr(input logic [7:0] op, input logic [23:0] wd, input int nw);
      logic [159:0] rd;
      xfer(fcfg_pkg::CMD_WR_ENABLE, 24'h00_0000, 0, 0, 0, rd);
      xfer(op, wd, nw, 0, 0, rd);
   endtask : wr
   // Pin reset: data line three falls while deselected
   task automatic pin_reset();
      @(posedge clk_sys);
      #2 pins.dq3 = 1'b0;
      #400 pins.dq3 = 1'b1;
      #1000;
   endtask : pin_reset
endmodule : fcfg_host
`default_nettype wire

//--- fcfg_pkg.sv
// Package: constants and types of the flash configuration register block
package fcfg_pkg;
   // ---------------------------------------------------------------
   // Command opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
   localparam logic [7:0] CMD_RD_NV = 8'hb5;
   localparam logic [7:0] CMD_WR_NV = 8'hb1;
   localparam logic [7:0] CMD_RD_VCR = 8'h85;
   localparam logic [7:0] CMD_WR_VCR = 8'h81;
   localparam logic [7:0] CMD_FAST_RD = 8'h0b;
   // ---------------------------------------------------------------
   // Nonvolatile configuration fields
   // ---------------------------------------------------------------
   localparam int NV_DUMMY_LSB = 12;
   localparam int NV_XIP_LSB = 9;
   localparam int NV_DRIVE_LSB = 6;
   localparam int NV_HOLD_BIT = 4;
   localparam int NV_QUAD_BIT = 3;
   localparam int NV_DUAL_BIT = 2;
   localparam logic [15:0] NV_RESET = 16'hffff;
   localparam logic [15:0] NV_FIXED_ONES = 16'h0003;
   // ---------------------------------------------------------------
   // Volatile configuration fields
   // ---------------------------------------------------------------
   localparam int VCR_DUMMY_LSB = 4;
   localparam int VCR_XIP_BIT = 3;
   localparam int VCR_WRAP_LSB = 0;
   localparam logic [7:0] VCR_RESET = 8'hfb;
   localparam logic [7:0] VCR_FIXED_ZERO = 8'h04;
   // ---------------------------------------------------------------
   // Field codes
   // ---------------------------------------------------------------
   localparam logic [3:0] DUMMY_AUTO_LO = 4'h0;
   localparam logic [3:0] DUMMY_AUTO_HI = 4'hf;
   localparam logic [3:0] DUMMY_DEFAULT = 4'h8;
   localparam logic [2:0] XIP_OFF = 3'h7;
   localparam logic [1:0] WRAP_16 = 2'h0;
   localparam logic [1:0] WRAP_32 = 2'h1;
   localparam logic [1:0] WRAP_64 = 2'h2;
   localparam logic [1:0] WRAP_CONT = 2'h3;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} fcfg_proto_e;
   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_IN, ST_OUT, ST_IGNORE
   } fcfg_state_e;
   typedef struct packed {
      logic [3:0] dummy;
      logic [2:0] xip_mode;
      logic [2:0] drive;
      logic hold_en;
      fcfg_proto_e proto;
      logic xip_dis;
      logic [1:0] wrap;
   } fcfg_cfg_s;
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic dq0;
      logic dq3;
   } fcfg_pins_s;
   localparam fcfg_cfg_s CFG_RESET = '{
      dummy: 4'hf, xip_mode: 3'h7, drive: 3'h7, hold_en: 1'b1,
      proto: PROTO_EXT, xip_dis: 1'b1, wrap: 2'h3};
endpackage : fcfg_pkg

//--- fcfg_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module fcfg_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // First stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta <= INIT;
         q <= INIT;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : fcfg_sync
`default_nettype wire

//--- fcfg_tb_top.sv
// Testbench for the flash configuration register block
`timescale 1ns/1ns
`default_nettype none
module fcfg_tb_top;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic dq1_out, dq1_oe, arr_rd;
   logic [23:0] arr_addr, a, m;
   logic [7:0] arr_data, v;
   logic [15:0] nv, nv_m;
   logic [7:0] vcr_m;
   logic [3:0] dummy_cycles;
   logic [159:0] rd;
   fcfg_pkg::fcfg_cfg_s cfg, cfg_m;
   fcfg_pkg::fcfg_pins_s pins;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   int rd_pulses = 0;
   logic oe_hi = 1'b0;
   // -----
   // Models
   // -----
   function automatic logic [7:0] mem(logic [23:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h5a;
   endfunction : mem
   function automatic logic [3:0] dc(logic [3:0] c);
      return (c == 4'h0 || c == 4'hf) ? fcfg_pkg::DUMMY_DEFAULT : c;
   endfunction : dc
   function automatic fcfg_pkg::fcfg_cfg_s from_nv(logic [15:0] n);
      fcfg_pkg::fcfg_cfg_s c;
      c.dummy = n[15:12];
      c.xip_mode = n[11:9];
      c.drive = n[8:6];
      c.hold_en = n[4];
      c.proto = !n[3] ? fcfg_pkg::PROTO_QUAD : !n[2] ? fcfg_pkg::PROTO_DUAL : fcfg_pkg::PROTO_EXT;
      c.xip_dis = n[11:9] == 3'h7;
      c.wrap = 2'h3;
      return c;
   endfunction : from_nv
   // Array answers combinationally, as the engine expects
   assign arr_data = mem(arr_addr);
   // Clock at 20 MHz
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   fcfg_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .pins(pins), .arr_data(arr_data),
      .dq1_out(dq1_out), .dq1_oe(dq1_oe), .arr_addr(arr_addr), .arr_rd(arr_rd), .cfg(cfg),
      .dummy_cycles(dummy_cycles));
   fcfg_host host_u (.clk_sys(clk_sys), .dq1_out(dq1_out), .pins(pins));
   // Output enable as the host sees it at each link clock rise
   always @(posedge pins.sclk) begin
      oe_hi <= dq1_oe;
   end
   // Array fetches, counted away from the edge that launches them
   always @(negedge clk_sys) begin
      if (arr_rd) begin
         rd_pulses++;
      end
   end
   // -----
   // Checks
   // -----
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_cfg();
      check_count++;
      if (cfg !== cfg_m) begin
         errors++;
         $display("[ERR] %0t config got %h exp %h", $time, cfg, cfg_m);
      end
   endtask : chk_cfg
   // Read both registers back and compare the live configuration
   task automatic regs(input string t);
      host_u.xfer(fcfg_pkg::CMD_RD_NV, 24'h00_0000, 0, 0, 16, rd);
      chk(24'({rd[7:0], rd[15:8]}), 24'(nv_m), "nv");
      chk(24'({oe_hi, dq1_oe}), 24'h00_0002, "oe");
      host_u.xfer(fcfg_pkg::CMD_RD_VCR, 24'h00_0000, 0, 0, 8, rd);
      chk(24'(rd[7:0]), 24'(vcr_m), "vcr");
      chk_cfg();
      chk(24'(dummy_cycles), 24'(dc(cfg_m.dummy)), "dummy");
      $display("test %s done", t);
   endtask : regs
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   // Hang guard, well above the expected run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         $display("[ERR] %0t timeout", $time);
         print_verdict();
      end
   end
   // -----
   // Main sequence
   // -----
   initial begin
      void'($urandom(36474));
      repeat (3) @(posedge clk_sys);
      #2 rstn = 1'b1;
      repeat (8) @(posedge clk_sys);
      nv_m = 16'hffff;
      vcr_m = 8'hfb;
      cfg_m = from_nv(nv_m);
      regs("reset values");
      // Write without write enable must leave everything alone
      host_u.xfer(fcfg_pkg::CMD_WR_VCR, 24'h00_0000, 8, 0, 0, rd);
      regs("refused write");
      // Every wrap code, with a fast read crossing the block end, wrapped except under code 11
      for (int w = 0; w < 4; w++) begin
         v = {(w == 0) ? 4'h0 : 4'($urandom_range(1, 15)), 1'($urandom), 1'b1, 2'(w)};
         host_u.wr(fcfg_pkg::CMD_WR_VCR, 24'(v), 8);
         vcr_m = v & 8'hfb;
         cfg_m.dummy = v[7:4];
         cfg_m.xip_dis = v[3];
         cfg_m.wrap = v[1:0];
         regs("vcr write");
         a = {1'b0, 17'($urandom), 6'h3c};
         rd_pulses = 0;
         host_u.xfer(fcfg_pkg::CMD_FAST_RD, a, 24, int'(dc(v[7:4])), 160, rd);
         // One prefetch after the dummies, then one per byte sent
         chk(24'(rd_pulses), 24'h00_0015, "fetches");
         m = 24'h00_0010 << w;
         for (int i = 0; i < 20; i++) begin
            chk(24'(rd[159 - 8 * i -: 8]), 24'(mem(a)), "byte");
            a = (w == 3) ? a + 24'h00_0001 : (a & ~(m - 24'h00_0001)) | ((a + 24'h00_0001) & (m - 24'h00_0001));
         end
         $display("test wrap %0d done", w);
      end
      // Nonvolatile image takes effect only on reset; every protocol pair
      for (int k = 0; k < 4; k++) begin
         nv = 16'($urandom);
         nv[4] = (k != 3);
         nv[3:2] = 2'(k);
         host_u.wr(fcfg_pkg::CMD_WR_NV, 24'({nv[7:0], nv[15:8]}), 16);
         nv_m = nv | 16'h0003;
         regs("nv write");
         host_u.pin_reset();
         cfg_m = from_nv(nv_m);
         vcr_m = {nv_m[15:12], cfg_m.xip_dis, 3'b011};
         regs("pin reset");
      end
      // Second power-on in mid-run returns a fresh part
      @(posedge clk_sys);
      #2 rstn = 1'b0;
      repeat (3) @(posedge clk_sys);
      #2 rstn = 1'b1;
      repeat (8) @(posedge clk_sys);
      nv_m = 16'hffff;
      vcr_m = 8'hfb;
      cfg_m = from_nv(nv_m);
      regs("power on");
      print_verdict();
   end
endmodule : fcfg_tb_top
`default_nettype wire

//--- fcfg_top.sv
// Configuration register pair of a serial NOR flash behind its serial pins
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Read command returns 16-bit nonvolatile register; write command updates it.
// - At power-on and each reset, nonvolatile contents load the internal configuration.
// - Read command returns 8-bit volatile register; write command updates it.
// - Completed volatile read or write copies the volatile register into configuration.
// - Nonvolatile bits 15:12 give dummy cycles; 0000 and 1111 mean default.
// - Volatile bits 7:4 give dummy cycles; 0000 and 1111 mean default.
// - Nonvolatile bits 11:9 pick the XIP mode after power-on; 111 disables.
// - Nonvolatile bits 8:6 hold the output drive strength code.
// - Nonvolatile bit 4 enables hold/reset use of data line three.
// - Nonvolatile bit 3 low enables quad command input.
// - Nonvolatile bit 2 low enables dual command input.
// - Both bits 2 and 3 low selects quad; quad beats dual.
// - Volatile bit 3 low enables XIP, high disables; default high.
// - Volatile bits 1:0 select 16, 32 or 64-byte aligned read wrap.
// - Volatile wrap code 11 reads continuously through the array.
// - Wrapped reads climb to the block end, then restart at its start.
module fcfg_top (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire fcfg_pkg::fcfg_pins_s pins,
   input wire logic [7:0] arr_data,
   output logic dq1_out,
   output logic dq1_oe,
   output logic [23:0] arr_addr,
   output logic arr_rd,
   output fcfg_pkg::fcfg_cfg_s cfg,
   output logic [3:0] dummy_cycles
);
   // ---------------------------------------------------------------
   // Reset release and pin capture
   // ---------------------------------------------------------------
   logic rst_q1;
   logic rst_n_s;
   fcfg_pkg::fcfg_pins_s pin_s;
   logic sclk_d;
   logic cs_n_d;
   logic dq3_d;

   // Reset arrives asynchronously, releases on the clock
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_q1 <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n_s <= rst_q1;
      end
   end

   fcfg_sync #(.W(4), .INIT(4'h9)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n_s),
      .ce(ce),
      .d(pins),
      .q(pin_s)
   );

   // Delayed copies for edge finding
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         sclk_d <= 1'b0;
         cs_n_d <= 1'b1;
         dq3_d <= 1'b1;
      end else if (ce) begin
         sclk_d <= pin_s.sclk;
         cs_n_d <= pin_s.cs_n;
         dq3_d <= pin_s.dq3;
      end
   end

   // ---------------------------------------------------------------
   // Frame events
   // ---------------------------------------------------------------
   logic cs_low;
   logic cs_fall;
   logic cs_end;
   logic hold;
   logic link_rst;
   logic step_r;
   logic step_f;

   // Data line three is hold inside a frame, reset outside it
   assign cs_low = ~pin_s.cs_n;
   assign cs_fall = cs_low & cs_n_d;
   assign cs_end = pin_s.cs_n & ~cs_n_d;
   assign hold = cfg.hold_en & ~pin_s.dq3 & cs_low;
   assign link_rst = cfg.hold_en & ~pin_s.dq3 & dq3_d & ~cs_low;
   assign step_r = pin_s.sclk & ~sclk_d & cs_low & ~hold;
   assign step_f = ~pin_s.sclk & sclk_d & cs_low & ~hold;

   // ---------------------------------------------------------------
   // Command engine
   // ---------------------------------------------------------------
   fcfg_pkg::fcfg_state_e st;
   fcfg_pkg::fcfg_state_e next_st;
   logic [4:0] cnt;
   logic [7:0] sh_in;
   logic [7:0] in_byte;
   logic [7:0] cmd;
   logic [7:0] src_cmd;
   logic [23:0] addr;
   logic [23:0] next_addr;
   logic [15:0] wr_buf;
   logic [1:0] byte_cnt;
   logic [3:0] dummy_n;
   logic dummy_last;
   logic byte_done;

   assign in_byte = {sh_in[6:0], pin_s.dq0};
   assign byte_done = step_r & (cnt == 5'h07);
   assign dummy_last = step_r & (st == fcfg_pkg::ST_DUMMY)
      & (cnt == {1'b0, dummy_n - 4'h1});
   assign src_cmd = (st == fcfg_pkg::ST_CMD) ? in_byte : cmd;

   // Dummy code zero behaves as the default code
   always_comb begin
      if (cfg.dummy == fcfg_pkg::DUMMY_AUTO_LO || cfg.dummy == fcfg_pkg::DUMMY_AUTO_HI) begin
         dummy_n = fcfg_pkg::DUMMY_DEFAULT;
      end else begin
         dummy_n = cfg.dummy;
      end
   end

   // Phase after the opcode byte
   always_comb begin
      case (in_byte)
         fcfg_pkg::CMD_RD_NV: next_st = fcfg_pkg::ST_OUT;
         fcfg_pkg::CMD_RD_VCR: next_st = fcfg_pkg::ST_OUT;
         fcfg_pkg::CMD_WR_NV: next_st = fcfg_pkg::ST_IN;
         fcfg_pkg::CMD_WR_VCR: next_st = fcfg_pkg::ST_IN;
         fcfg_pkg::CMD_FAST_RD: next_st = fcfg_pkg::ST_ADDR;
         default: next_st = fcfg_pkg::ST_IGNORE;
      endcase
   end

   // Phase sequencing, one step per rising link clock
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         st <= fcfg_pkg::ST_IDLE;
         cnt <= 5'h00;
      end else if (ce) begin
         if (cs_fall) begin
            st <= fcfg_pkg::ST_CMD;
            cnt <= 5'h00;
         end else if (!cs_low) begin
            st <= fcfg_pkg::ST_IDLE;
         end else if (step_r) begin
            case (st)
               fcfg_pkg::ST_CMD: begin
                  cnt <= (cnt == 5'h07) ? 5'h00 : cnt + 5'h01;
                  if (cnt == 5'h07) begin
                     st <= next_st;
                  end
               end
               fcfg_pkg::ST_ADDR: begin
                  cnt <= (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
                  if (cnt == 5'h17) begin
                     st <= fcfg_pkg::ST_DUMMY;
                  end
               end
               fcfg_pkg::ST_DUMMY: begin
                  cnt <= dummy_last ? 5'h00 : cnt + 5'h01;
                  if (dummy_last) begin
                     st <= fcfg_pkg::ST_OUT;
                  end
               end
               fcfg_pkg::ST_IN, fcfg_pkg::ST_OUT: begin
                  cnt <= (cnt == 5'h07) ? 5'h00 : cnt + 5'h01;
               end
               default: begin
               end
            endcase
         end
      end
   end

   fcfg_wrap u_wrap (
      .cur(addr),
      .mode(cfg.wrap),
      .next(next_addr)
   );

   // Shift-in, opcode, address pointer and write data
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         sh_in <= 8'h00;
         cmd <= 8'h00;
         addr <= 24'h00_0000;
         wr_buf <= 16'h0000;
         byte_cnt <= 2'h0;
      end else if (ce) begin
         if (cs_fall) begin
            byte_cnt <= 2'h0;
         end
         if (step_r) begin
            sh_in <= in_byte;
         end
         if (byte_done && st == fcfg_pkg::ST_CMD) begin
            cmd <= in_byte;
         end
         if (step_r && st == fcfg_pkg::ST_ADDR) begin
            addr <= {addr[22:0], pin_s.dq0};
         end
         // Pointer always names the next byte to fetch
         if (dummy_last || (byte_done && st == fcfg_pkg::ST_OUT
               && cmd == fcfg_pkg::CMD_FAST_RD)) begin
            addr <= next_addr;
         end
         // First byte lands low, bytes after the third are dropped
         if (byte_done && st == fcfg_pkg::ST_IN && byte_cnt != 2'h3) begin
            wr_buf <= {in_byte, wr_buf[15:8]};
            byte_cnt <= byte_cnt + 2'h1;
         end
      end
   end

   assign arr_addr = addr;
   assign arr_rd = ce & (dummy_last | (byte_done & st == fcfg_pkg::ST_OUT
      & cmd == fcfg_pkg::CMD_FAST_RD));

   // ---------------------------------------------------------------
   // Read data path
   // ---------------------------------------------------------------
   logic [15:0] nonvolatile_config;
   logic [7:0] volatile_config;
   logic [7:0] out_sh;
   logic out_sel;
   logic [7:0] load_val;
   logic load;

   assign load = (byte_done && (st == fcfg_pkg::ST_CMD || st == fcfg_pkg::ST_OUT))
      || dummy_last;

   // Nonvolatile read alternates low then high byte
   always_comb begin
      case (src_cmd)
         fcfg_pkg::CMD_RD_NV: load_val = out_sel ? nonvolatile_config[15:8] : nonvolatile_config[7:0];
         fcfg_pkg::CMD_RD_VCR: load_val = volatile_config;
         default: load_val = arr_data;
      endcase
   end

   // Load on rising edge, shift out on falling edge
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         out_sh <= 8'h00;
         out_sel <= 1'b0;
         dq1_out <= 1'b0;
         dq1_oe <= 1'b0;
      end else if (ce) begin
         dq1_oe <= cs_low & (st == fcfg_pkg::ST_OUT);
         if (cs_fall) begin
            out_sel <= 1'b0;
         end else if (load && src_cmd == fcfg_pkg::CMD_RD_NV) begin
            out_sel <= ~out_sel;
         end
         if (load) begin
            out_sh <= load_val;
         end else if (step_f && st == fcfg_pkg::ST_OUT) begin
            dq1_out <= out_sh[7];
            out_sh <= {out_sh[6:0], 1'b0};
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers and internal configuration
   // ---------------------------------------------------------------
   logic wel;
   logic wren_done;
   logic nv_commit;
   logic vcr_commit;
   logic vcr_read_done;
   logic [7:0] vcr_new;

   // Download of the nonvolatile image
   function automatic fcfg_pkg::fcfg_cfg_s cfg_from_nv(input logic [15:0] nv);
      fcfg_pkg::fcfg_cfg_s c;
      c.dummy = nv[fcfg_pkg::NV_DUMMY_LSB +: 4];
      c.xip_mode = nv[fcfg_pkg::NV_XIP_LSB +: 3];
      c.drive = nv[fcfg_pkg::NV_DRIVE_LSB +: 3];
      c.hold_en = nv[fcfg_pkg::NV_HOLD_BIT];
      if (!nv[fcfg_pkg::NV_QUAD_BIT]) begin
         c.proto = fcfg_pkg::PROTO_QUAD;
      end else if (!nv[fcfg_pkg::NV_DUAL_BIT]) begin
         c.proto = fcfg_pkg::PROTO_DUAL;
      end else begin
         c.proto = fcfg_pkg::PROTO_EXT;
      end
      c.xip_dis = (nv[fcfg_pkg::NV_XIP_LSB +: 3] == fcfg_pkg::XIP_OFF);
      c.wrap = fcfg_pkg::WRAP_CONT;
      return c;
   endfunction : cfg_from_nv

   // Volatile image overlays only its own fields
   function automatic fcfg_pkg::fcfg_cfg_s cfg_from_vcr(
      input fcfg_pkg::fcfg_cfg_s base, input logic [7:0] v);
      fcfg_pkg::fcfg_cfg_s c;
      c = base;
      c.dummy = v[fcfg_pkg::VCR_DUMMY_LSB +: 4];
      c.xip_dis = v[fcfg_pkg::VCR_XIP_BIT];
      c.wrap = v[fcfg_pkg::VCR_WRAP_LSB +: 2];
      return c;
   endfunction : cfg_from_vcr

   // Volatile reload follows the nonvolatile image
   function automatic logic [7:0] vcr_from_nv(input logic [15:0] nv);
      return {nv[fcfg_pkg::NV_DUMMY_LSB +: 4],
         nv[fcfg_pkg::NV_XIP_LSB +: 3] == fcfg_pkg::XIP_OFF, 1'b0,
         fcfg_pkg::WRAP_CONT};
   endfunction : vcr_from_nv

   // Writes count only as whole bytes of the right number
   assign wren_done = cs_end & (cmd == fcfg_pkg::CMD_WR_ENABLE)
      & (st == fcfg_pkg::ST_IGNORE);
   assign nv_commit = cs_end & wel & (cmd == fcfg_pkg::CMD_WR_NV)
      & (st == fcfg_pkg::ST_IN) & (cnt == 5'h00) & (byte_cnt == 2'h2);
   assign vcr_commit = cs_end & wel & (cmd == fcfg_pkg::CMD_WR_VCR)
      & (st == fcfg_pkg::ST_IN) & (cnt == 5'h00) & (byte_cnt == 2'h1);
   assign vcr_read_done = cs_end & (cmd == fcfg_pkg::CMD_RD_VCR)
      & (st == fcfg_pkg::ST_OUT);
   assign vcr_new = wr_buf[15:8] & ~fcfg_pkg::VCR_FIXED_ZERO;

   // Write enable latch, cleared by a taken write
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         wel <= 1'b0;
      end else if (ce) begin
         if (link_rst) begin
            wel <= 1'b0;
         end else if (wren_done) begin
            wel <= 1'b1;
         end else if (nv_commit || vcr_commit) begin
            wel <= 1'b0;
         end
      end
   end

   // Nonvolatile image: untouched by the pin reset
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         nonvolatile_config <= fcfg_pkg::NV_RESET;
      end else if (ce && nv_commit) begin
         nonvolatile_config <= wr_buf | fcfg_pkg::NV_FIXED_ONES;
      end
   end

   // Volatile image
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         volatile_config <= fcfg_pkg::VCR_RESET;
      end else if (ce) begin
         if (link_rst) begin
            volatile_config <= vcr_from_nv(nonvolatile_config);
         end else if (vcr_commit) begin
            volatile_config <= vcr_new;
         end
      end
   end

   // Internal configuration steering the device
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         cfg <= fcfg_pkg::CFG_RESET;
         dummy_cycles <= fcfg_pkg::DUMMY_DEFAULT;
      end else if (ce) begin
         dummy_cycles <= dummy_n;
         if (link_rst) begin
            cfg <= cfg_from_nv(nonvolatile_config);
         end else if (vcr_commit) begin
            cfg <= cfg_from_vcr(cfg, vcr_new);
         end else if (vcr_read_done) begin
            cfg <= cfg_from_vcr(cfg, volatile_config);
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_s);

   a_nv_write_gate: assert property ($changed(nonvolatile_config) |->
      $past(wel) && $past(cmd) == fcfg_pkg::CMD_WR_NV)
      else $error("nonvolatile register changed without enabled write");
   a_reserved_bits: assert property (nonvolatile_config[1:0] == 2'h3 && !volatile_config[2])
      else $error("reserved configuration bits wrong");
   a_vcr_to_cfg: assert property (ce && vcr_commit |=>
      cfg.dummy == $past(wr_buf[15:12]) && cfg.wrap == $past(wr_buf[9:8]))
      else $error("volatile write did not reach configuration");
   a_reset_reload: assert property (ce && link_rst |=>
      cfg.dummy == $past(nonvolatile_config[15:12]) && cfg.xip_mode == $past(nonvolatile_config[11:9])
      && cfg.drive == $past(nonvolatile_config[8:6]) && cfg.hold_en == $past(nonvolatile_config[4]))
      else $error("reset did not load nonvolatile image");
   a_quad_priority: assert property (ce && link_rst && !nonvolatile_config[3] |=>
      cfg.proto == fcfg_pkg::PROTO_QUAD)
      else $error("quad protocol not selected");
   a_dual_select: assert property (ce && link_rst && nonvolatile_config[3] && !nonvolatile_config[2] |=>
      cfg.proto == fcfg_pkg::PROTO_DUAL)
      else $error("dual protocol not selected");
   a_dummy_length: assert property ($rose(st == fcfg_pkg::ST_OUT) && $past(st) ==
      fcfg_pkg::ST_DUMMY |-> $past(cnt) == {1'b0, dummy_n - 4'h1})
      else $error("dummy phase length wrong");
   a_wrap_block: assert property (ce && byte_done && st == fcfg_pkg::ST_OUT
      && cmd == fcfg_pkg::CMD_FAST_RD && cfg.wrap != fcfg_pkg::WRAP_CONT
      |=> addr[23:6] == $past(addr[23:6]))
      else $error("wrapped read left its block");
   a_cont_incr: assert property (ce && byte_done && st == fcfg_pkg::ST_OUT
      && cmd == fcfg_pkg::CMD_FAST_RD && cfg.wrap == fcfg_pkg::WRAP_CONT
      |=> addr == $past(addr) + 24'h00_0001)
      else $error("continuous read did not advance");
   a_vcr_readout: assert property (ce && load && src_cmd == fcfg_pkg::CMD_RD_VCR
      |=> out_sh == $past(volatile_config))
      else $error("volatile read byte wrong");

   c_nv_write: cover property (nv_commit);
   c_vcr_write: cover property (vcr_commit);
   c_wrap_read: cover property (arr_rd && cfg.wrap == fcfg_pkg::WRAP_16);
   c_pin_reset: cover property (link_rst);
endmodule : fcfg_top
`default_nettype wire

//--- fcfg_wrap.sv
// Next read address with optional aligned wrap
`timescale 1ns/1ns
`default_nettype none
module fcfg_wrap (
   input wire logic [23:0] cur,
   input wire logic [1:0] mode,
   output logic [23:0] next
);
   logic [23:0] mask;
   logic [23:0] inc;
   // Low bits inside the wrap block
   always_comb begin
      case (mode)
         fcfg_pkg::WRAP_16: mask = 24'h00_000f;
         fcfg_pkg::WRAP_32: mask = 24'h00_001f;
         fcfg_pkg::WRAP_64: mask = 24'h00_003f;
         default: mask = 24'hff_ffff;
      endcase
   end
   // Upper bits held so the block start is revisited
   assign inc = cur + 24'h00_0001;
   assign next = (cur & ~mask) | (inc & mask);
endmodule : fcfg_wrap
`default_nettype wire
